// file: shared/crf_regs.vh
`ifndef CRF_REGS_VH
`define CRF_REGS_VH

// Frame subtypes
`define CRF_SUBTYPE_LEGACY 8'h00
`define CRF_SUBTYPE_HDLC_POS 8'h01
`define CRF_SUBTYPE_ETHERNET 8'h02
`define CRF_SUBTYPE_ATM_CELL 8'h03
`define CRF_SUBTYPE_AAL5_FRAME 8'h04
`define CRF_SUBTYPE_MULTICHANNEL_HDLC 8'h05
`define CRF_SUBTYPE_MULTICHANNEL_RAW 8'h06
`define CRF_SUBTYPE_MULTICHANNEL_ATM 8'h07

// Flag byte fields
`define CRF_FLAG_IF_LSB 0
`define CRF_FLAG_VARY_BIT 2
`define CRF_FLAG_TRUNC_BIT 3
`define CRF_FLAG_RXERR_BIT 4
`define CRF_FLAG_INTERR_BIT 5

// Record byte offsets
`define CRF_OFS_TS 16'h0000
`define CRF_OFS_SUBTYPE 16'h0008
`define CRF_OFS_FLAGS 16'h0009
`define CRF_OFS_RLEN 16'h000A
`define CRF_OFS_LCTR 16'h000C
`define CRF_OFS_WLEN 16'h000E
`define CRF_OFS_OFFSET 16'h0010
`define CRF_OFS_PAD 16'h0011
`define CRF_GEN_HDR_LEN 16'h0010
`define CRF_ETH_HDR_LEN 16'h0012
`define CRF_CAP_MAX (16'hFFFF - `CRF_ETH_HDR_LEN)

// Loss counter
`define CRF_LCTR_RESET 16'h0000
`define CRF_LCTR_MAX 16'hFFFF

// Time base
`define CRF_CLK_HZ 125000000
`define CRF_FRAC_ONE 64'h0000000100000000
`define CRF_FRAC_STEP (`CRF_FRAC_ONE / `CRF_CLK_HZ)
`define CRF_FRAC_REM (`CRF_FRAC_ONE % `CRF_CLK_HZ)
`define CRF_TS_ZERO_BITS 5

`endif

// file: hw/crf_ts_clock.v
`timescale 1ns/10ps
`default_nettype none
`include "crf_regs.vh"
module crf_ts_clock (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Seconds load
	input wire load_i,
	input wire [31:0] sec_i,
	// Current time
	output wire [63:0] ts_o
);
	localparam [63:0] STEP_W = `CRF_FRAC_STEP;
	localparam [63:0] REM_W = `CRF_FRAC_REM;
	localparam [31:0] STEP = STEP_W[31:0];
	localparam [31:0] REM = REM_W[31:0];
	localparam [31:0] HZ = `CRF_CLK_HZ;
	localparam [31:0] LOW_MASK = ~((32'h00000001 << `CRF_TS_ZERO_BITS) - 32'h1);

	reg [31:0] sec_r;
	reg [31:0] frac_r;
	reg [31:0] err_r;
	reg [63:0] ts_r;
	wire [32:0] err_sum;
	wire carry_one;
	wire [32:0] frac_sum;

	// Fraction advances by 2^32/clock rate; remainder spread Bresenham-style
	assign err_sum = {1'b0, err_r} + {1'b0, REM};
	assign carry_one = (err_sum >= {1'b0, HZ});
	assign frac_sum = {1'b0, frac_r} + {1'b0, STEP} + {32'h0, carry_one};

	always @(posedge clk_i) begin
		if (rst_i) begin
			sec_r <= 32'h00000000;
			frac_r <= 32'h00000000;
			err_r <= 32'h00000000;
			ts_r <= 64'h0000000000000000;
		end else begin
			if (load_i) begin
				sec_r <= sec_i;
				frac_r <= 32'h00000000;
				err_r <= 32'h00000000;
			end else begin
				frac_r <= frac_sum[31:0];
				err_r <= carry_one ? (err_sum[31:0] - HZ) : err_sum[31:0];
				sec_r <= sec_r + {31'h0, frac_sum[32]};
			end
			ts_r <= {sec_r, frac_r & LOW_MASK};
		end
	end

	assign ts_o = ts_r;
endmodule // crf_ts_clock
`default_nettype wire

// file: hw/crf_framer.v
`timescale 1ns/10ps
`default_nettype none
`include "crf_regs.vh"
module crf_framer (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Time of day load
	input wire ts_load_i,
	input wire [31:0] ts_sec_i,
	// Arrival and drop events
	input wire sof_i,
	input wire drop_i,
	// Frame descriptor
	input wire desc_valid_i,
	output wire desc_ready_o,
	input wire [15:0] desc_cap_len_i,
	input wire [15:0] desc_wire_len_i,
	input wire [1:0] desc_if_i,
	input wire desc_trunc_i,
	input wire desc_rx_err_i,
	input wire desc_int_err_i,
	// Payload bytes
	input wire pay_valid_i,
	output wire pay_ready_o,
	input wire [7:0] pay_data_i,
	// Record byte stream
	output wire rec_valid_o,
	input wire rec_ready_i,
	output wire [7:0] rec_data_o,
	output wire rec_last_o,
	// Status
	output wire busy_o,
	output wire [15:0] lctr_o
);
	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_HDR = 2'b01;
	localparam [1:0] ST_PAY = 2'b10;
	localparam [15:0] HDR_LAST = `CRF_ETH_HDR_LEN - 16'h0001;

	wire [63:0] ts_now;

	reg [1:0] state_r;
	reg [15:0] idx_r;
	reg [15:0] cap_r;
	reg [15:0] rlen_r;
	reg [15:0] wlen_r;
	reg [15:0] lctr_r;
	reg [15:0] lctr_nxt;
	reg [15:0] rec_lctr_r;
	reg [15:0] last_rlen_r;
	reg [7:0] flags_r;
	reg [63:0] stamp_r;
	reg [63:0] rec_ts_r;
	reg have_len_r;
	reg vary_r;
	reg stamp_pend_r;
	reg ovr_r;
	reg desc_ready_r;
	reg pay_ready_r;
	reg rec_valid_r;
	reg [7:0] rec_data_r;
	reg rec_last_r;
	reg busy_r;

	wire accept;
	wire out_free;
	wire take;
	wire cap_big;
	wire [15:0] cap_eff;
	wire [15:0] rlen_new;
	wire vary_nxt;
	reg [7:0] flags_nxt;
	wire pay_end;

	crf_ts_clock u_ts (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(ts_load_i),
		.sec_i(ts_sec_i),
		.ts_o(ts_now)
	);

	assign accept = desc_valid_i && desc_ready_r;
	assign out_free = !rec_valid_r || rec_ready_i;
	assign take = pay_valid_i && pay_ready_r;
	assign pay_end = (idx_r == cap_r - 16'h0001);

	// Clamp so the 16-bit length field cannot wrap
	assign cap_big = desc_cap_len_i > `CRF_CAP_MAX;
	assign cap_eff = cap_big ? `CRF_CAP_MAX : desc_cap_len_i;
	assign rlen_new = cap_eff + `CRF_ETH_HDR_LEN;
	assign vary_nxt = vary_r || (have_len_r && rlen_new != last_rlen_r);

	// Flag byte built from the field positions
	always @* begin
		flags_nxt = 8'h00;
		flags_nxt[`CRF_FLAG_IF_LSB +: 2] = desc_if_i;
		flags_nxt[`CRF_FLAG_VARY_BIT] = vary_nxt;
		flags_nxt[`CRF_FLAG_TRUNC_BIT] = desc_trunc_i || cap_big;
		flags_nxt[`CRF_FLAG_RXERR_BIT] = desc_rx_err_i;
		flags_nxt[`CRF_FLAG_INTERR_BIT] = desc_int_err_i || ovr_r;
	end

	// Header byte at a given record offset
	function [7:0] hdr_byte;
		input [15:0] idx;
		reg [2:0] lane;
		begin
			lane = idx[2:0];
			hdr_byte = 8'h00;
			if (idx < `CRF_OFS_SUBTYPE) begin
				hdr_byte = rec_ts_r[{lane, 3'b000} +: 8];
			end else begin
				case (idx)
					`CRF_OFS_SUBTYPE: hdr_byte = `CRF_SUBTYPE_ETHERNET;
					`CRF_OFS_FLAGS: hdr_byte = flags_r;
					`CRF_OFS_RLEN: hdr_byte = rlen_r[15:8];
					`CRF_OFS_RLEN + 16'h1: hdr_byte = rlen_r[7:0];
					`CRF_OFS_LCTR: hdr_byte = rec_lctr_r[15:8];
					`CRF_OFS_LCTR + 16'h1: hdr_byte = rec_lctr_r[7:0];
					`CRF_OFS_WLEN: hdr_byte = wlen_r[15:8];
					`CRF_OFS_WLEN + 16'h1: hdr_byte = wlen_r[7:0];
					`CRF_OFS_OFFSET: hdr_byte = 8'h00;
					`CRF_OFS_PAD: hdr_byte = 8'h00;
					default: hdr_byte = 8'h00;
				endcase
			end
		end
	endfunction

	// Loss counter: drops since last record, saturating
	always @* begin
		lctr_nxt = lctr_r;
		if (accept) begin
			// A drop in the same cycle counts toward the next record
			lctr_nxt = drop_i ? 16'h0001 : `CRF_LCTR_RESET;
		end else if (drop_i && lctr_r != `CRF_LCTR_MAX) begin
			lctr_nxt = lctr_r + 16'h0001;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			lctr_r <= `CRF_LCTR_RESET;
			rec_lctr_r <= `CRF_LCTR_RESET;
		end else begin
			lctr_r <= lctr_nxt;
			if (accept) begin
				rec_lctr_r <= lctr_r;
			end
		end
	end

	// Arrival stamp held until its descriptor is taken
	always @(posedge clk_i) begin
		if (rst_i) begin
			stamp_r <= 64'h0000000000000000;
			stamp_pend_r <= 1'b0;
		end else if (sof_i) begin
			stamp_r <= ts_now;
			stamp_pend_r <= 1'b1;
		end else if (accept) begin
			stamp_pend_r <= 1'b0;
		end
	end

	// Second arrival before the first was framed loses a stamp
	always @(posedge clk_i) begin
		if (rst_i) begin
			ovr_r <= 1'b0;
		end else if (sof_i && stamp_pend_r && !accept) begin
			ovr_r <= 1'b1;
		end else if (accept) begin
			ovr_r <= 1'b0;
		end
	end

	// Stamp that goes into the record being framed
	always @(posedge clk_i) begin
		if (rst_i) begin
			rec_ts_r <= 64'h0000000000000000;
		end else if (accept) begin
			rec_ts_r <= stamp_pend_r ? stamp_r : ts_now;
		end
	end

	// Descriptor capture
	always @(posedge clk_i) begin
		if (rst_i) begin
			cap_r <= 16'h0000;
			rlen_r <= 16'h0000;
			wlen_r <= 16'h0000;
			flags_r <= 8'h00;
		end else if (accept) begin
			cap_r <= cap_eff;
			rlen_r <= rlen_new;
			wlen_r <= desc_wire_len_i;
			flags_r <= flags_nxt;
		end
	end

	// Length history; varying flag is sticky once lengths differ
	always @(posedge clk_i) begin
		if (rst_i) begin
			last_rlen_r <= 16'h0000;
			have_len_r <= 1'b0;
			vary_r <= 1'b0;
		end else if (accept) begin
			last_rlen_r <= rlen_new;
			have_len_r <= 1'b1;
			vary_r <= vary_nxt;
		end
	end

	// Record emission
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= ST_IDLE;
			idx_r <= 16'h0000;
			desc_ready_r <= 1'b0;
			pay_ready_r <= 1'b0;
			rec_valid_r <= 1'b0;
			rec_data_r <= 8'h00;
			rec_last_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			if (rec_valid_r && rec_ready_i) begin
				rec_valid_r <= 1'b0;
			end
			case (state_r)
				ST_IDLE: begin
					pay_ready_r <= 1'b0;
					if (accept) begin
						desc_ready_r <= 1'b0;
						busy_r <= 1'b1;
						idx_r <= `CRF_OFS_TS;
						state_r <= ST_HDR;
					end else begin
						desc_ready_r <= 1'b1;
					end
				end
				ST_HDR: begin
					if (out_free) begin
						rec_data_r <= hdr_byte(idx_r);
						rec_valid_r <= 1'b1;
						rec_last_r <= (idx_r == HDR_LAST) && (cap_r == 16'h0000);
						if (idx_r == HDR_LAST) begin
							idx_r <= 16'h0000;
							if (cap_r == 16'h0000) begin
								state_r <= ST_IDLE;
								desc_ready_r <= 1'b1;
								busy_r <= 1'b0;
							end else begin
								state_r <= ST_PAY;
							end
						end else begin
							idx_r <= idx_r + 16'h0001;
						end
					end
				end
				ST_PAY: begin
					if (take) begin
						rec_data_r <= pay_data_i;
						rec_valid_r <= 1'b1;
						rec_last_r <= pay_end;
						pay_ready_r <= 1'b0;
						idx_r <= idx_r + 16'h0001;
						if (pay_end) begin
							state_r <= ST_IDLE;
							desc_ready_r <= 1'b1;
							busy_r <= 1'b0;
						end
					end else begin
						// Offer a byte only when the output slot is empty next
						pay_ready_r <= !(rec_valid_r && !rec_ready_i);
					end
				end
				default: begin
					state_r <= ST_IDLE;
					desc_ready_r <= 1'b0;
					pay_ready_r <= 1'b0;
					busy_r <= 1'b0;
				end
			endcase
		end
	end

	// Outputs straight from registers
	assign desc_ready_o = desc_ready_r;
	assign pay_ready_o = pay_ready_r;
	assign rec_valid_o = rec_valid_r;
	assign rec_data_o = rec_data_r;
	assign rec_last_o = rec_last_r;
	assign busy_o = busy_r;
	assign lctr_o = lctr_r;
endmodule // crf_framer
`default_nettype wire

// file: dv/crf_host_sink.sv
`timescale 1ns/10ps
`default_nettype none
module crf_host_sink (
	// Control
	input wire logic clk_i,
	input wire logic clr_i,
	input wire logic slow_i,
	// Record stream
	input wire logic vld_i,
	input wire logic [7:0] dat_i,
	input wire logic last_i,
	output logic rdy_o,
	output logic done_o
);
	logic [7:0] mem [0:63];
	logic [15:0] n = 16'h0000;
	initial rdy_o = 1'b0;
	initial done_o = 1'b0;
	// Stores every byte; the offset byte is kept but never interpreted
	always @(posedge clk_i) begin
		rdy_o <= slow_i ? ~rdy_o : 1'b1;
		if (clr_i) begin
			n <= 16'h0000;
			done_o <= 1'b0;
		end else if (vld_i && rdy_o) begin
			mem[n[5:0]] <= dat_i;
			n <= n + 16'h0001;
			done_o <= last_i;
		end
	end
endmodule // crf_host_sink
`default_nettype wire

// file: dv/crf_framer_sva.sv
`timescale 1ns/10ps
`default_nettype none
module crf_framer_sva (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Watched ports
	input wire drop_i,
	input wire desc_valid_i,
	input wire desc_ready_o,
	input wire pay_valid_i,
	input wire pay_ready_o,
	input wire [7:0] pay_data_i,
	input wire rec_valid_o,
	input wire rec_ready_i,
	input wire [7:0] rec_data_o,
	input wire rec_last_o,
	input wire busy_o,
	input wire [15:0] lctr_o
);
	logic [15:0] idx_r;
	wire take = desc_valid_i && desc_ready_o;
	wire hs = rec_valid_o && rec_ready_i;
	wire sat = lctr_o == 16'hFFFF;
	// Byte position within the current record
	always @(posedge clk_i)
		if (rst_i)
			idx_r <= 16'h0000;
		else if (hs)
			idx_r <= rec_last_o ? 16'h0000 : idx_r + 16'h0001;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	take_busy_a: assert property (take |=> !desc_ready_o && busy_o)
		else $error("no busy after take");
	first_byte_a: assert property (take |-> ##2 rec_valid_o)
		else $error("stamp byte late");
	hold_byte_a: assert property (rec_valid_o && !rec_ready_i |=>
		rec_valid_o && $stable(rec_data_o) && $stable(rec_last_o))
		else $error("byte not held");
	frac_zero_a: assert property (rec_valid_o && idx_r == 16'h0000 |->
		rec_data_o[4:0] == 5'h00) else $error("low fraction set");
	sub_type_a: assert property (rec_valid_o && idx_r == 16'h0008 |->
		rec_data_o == 8'h02) else $error("bad subtype");
	flag_rsv_a: assert property (rec_valid_o && idx_r == 16'h0009 |->
		rec_data_o[7:6] == 2'b00) else $error("reserved flags set");
	pay_copy_a: assert property (pay_valid_i && pay_ready_o |=>
		rec_valid_o && !pay_ready_o && rec_data_o == $past(pay_data_i))
		else $error("payload byte wrong");
	lctr_inc_a: assert property (drop_i && !take && !sat |=>
		lctr_o == $past(lctr_o) + 16'h0001) else $error("no count");
	lctr_sat_a: assert property (drop_i && !take && sat |=> sat)
		else $error("counter wrapped");
	lctr_clr_a: assert property (take |=> lctr_o[15:1] == 15'h0000)
		else $error("counter not restarted");
	take_c: cover property (take);
	last_c: cover property (hs && rec_last_o);
	sat_c: cover property (drop_i && sat);
endmodule // crf_framer_sva
bind crf_framer crf_framer_sva i_sva (.clk_i, .rst_i, .drop_i, .desc_valid_i,
	.desc_ready_o, .pay_valid_i, .pay_ready_o, .pay_data_i, .rec_valid_o,
	.rec_ready_i, .rec_data_o, .rec_last_o, .busy_o, .lctr_o);
`default_nettype wire

// file: dv/test_crf_framer.sv
`timescale 1ns/10ps
`default_nettype none
module test_crf_framer;
	logic clk_i = 0, rst_i = 1, ts_load_i = 0, sof_i = 0, drop_i = 0;
	logic desc_valid_i = 0, desc_trunc_i = 0, desc_rx_err_i = 0;
	logic desc_int_err_i = 0, pay_valid_i = 0, clr = 1, slow = 0;
	logic vary = 0, have = 0;
	logic [31:0] ts_sec_i = 32'h12345678;
	logic [15:0] desc_cap_len_i = 0, desc_wire_len_i = 0, prev_rl = 0;
	logic [1:0] desc_if_i = 0;
	logic [7:0] pay_data_i = 0;
	logic [63:0] prev_ts = 0;
	wire desc_ready_o, pay_ready_o, rec_valid_o, rec_ready_i, rec_last_o;
	wire busy_o, done;
	wire [7:0] rec_data_o;
	wire [15:0] lctr_o;
	int bad_count = 0, n_checks = 0;
	crf_framer i_dut (.clk_i, .rst_i, .ts_load_i, .ts_sec_i, .sof_i, .drop_i,
		.desc_valid_i, .desc_ready_o, .desc_cap_len_i, .desc_wire_len_i,
		.desc_if_i, .desc_trunc_i, .desc_rx_err_i, .desc_int_err_i,
		.pay_valid_i, .pay_ready_o, .pay_data_i, .rec_valid_o, .rec_ready_i,
		.rec_data_o, .rec_last_o, .busy_o, .lctr_o);
	crf_host_sink i_host (.clk_i, .clr_i(clr), .slow_i(slow),
		.vld_i(rec_valid_o), .dat_i(rec_data_o), .last_i(rec_last_o),
		.rdy_o(rec_ready_i), .done_o(done));
	initial forever #4 clk_i = ~clk_i;
	task complete_run;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string what, input logic [63:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task tmo(input string what);
		chk(what, 0, 1);
		complete_run();
	endtask
	// One record: drops, arrival, descriptor, payload, then header check
	task automatic send_rec(input logic [15:0] cap, input logic [1:0] ifn,
		input logic [2:0] err, input logic slw, dbl, input int drops);
		logic [7:0] m [0:63];
		logic [7:0] fl;
		logic [15:0] rl, lc;
		logic [63:0] ts;
		int i, k;
		@(negedge clk_i);
		slow = slw;
		clr = 1;
		drop_i = drops > 0;
		// Sink clear must meet at least one edge
		if (drops == 0) @(negedge clk_i);
		repeat (drops) @(negedge clk_i);
		drop_i = 0;
		sof_i = 1;
		clr = 0;
		@(negedge clk_i);
		sof_i = dbl;
		@(negedge clk_i);
		sof_i = 0;
		{desc_int_err_i, desc_rx_err_i, desc_trunc_i} = err;
		desc_if_i = ifn;
		desc_cap_len_i = cap;
		desc_wire_len_i = cap + 16'h0040;
		desc_valid_i = 1;
		for (k = 0; k < 40 && desc_ready_o !== 1'b1; k++) @(negedge clk_i);
		if (k == 40) tmo("desc_ready");
		@(negedge clk_i);
		desc_valid_i = 0;
		for (i = 0, k = 0; i < cap && k < 400; k++) begin
			pay_valid_i = 1;
			pay_data_i = 8'hA0 + i[7:0];
			if (pay_ready_o === 1'b1) i++;
			@(negedge clk_i);
		end
		pay_valid_i = 0;
		if (i < cap) tmo("payload take");
		for (k = 0; k < 400 && done !== 1'b1; k++) @(negedge clk_i);
		if (k == 400) tmo("record end");
		rl = cap + 16'h0012;
		lc = drops > 65535 ? 16'hFFFF : drops[15:0];
		if (have && rl != prev_rl) vary = 1;
		have = 1;
		prev_rl = rl;
		fl = {2'b00, err[2] | dbl, err[1:0], vary, ifn};
		for (i = 0; i < 64; i++) m[i] = i_host.mem[i];
		ts = {m[7], m[6], m[5], m[4], m[3], m[2], m[1], m[0]};
		chk("length", i_host.n, rl);
		chk("seconds", ts[63:32], ts_sec_i);
		chk("frac low", ts[4:0], 0);
		chk("stamp order", ts > prev_ts, 1);
		prev_ts = ts;
		chk("subtype", m[8], 8'h02);
		chk("flags", m[9], fl);
		chk("rlen", {m[10], m[11]}, rl);
		chk("loss", {m[12], m[13]}, lc);
		chk("wlen", {m[14], m[15]}, cap + 16'h0040);
		chk("pad", m[17], 0);
		chk("idle", {busy_o, desc_ready_o, lctr_o}, 18'h10000);
		for (i = 0; i < cap; i++) chk("payload", m[18 + i], 8'hA0 + i);
	endtask
	initial begin
		repeat (4) @(negedge clk_i);
		rst_i = 0;
		ts_load_i = 1;
		@(negedge clk_i);
		ts_load_i = 0;
		// Empty payload, fast sink, three drops
		send_rec(16'h0000, 2'h0, 3'h0, 0, 0, 3);
		// Truncated, slow sink, first length change
		send_rec(16'h0005, 2'h1, 3'h1, 1, 0, 0);
		// Link error
		send_rec(16'h0003, 2'h2, 3'h2, 0, 0, 1);
		// Internal error input, slow sink
		send_rec(16'h0003, 2'h3, 3'h4, 1, 0, 0);
		// Second arrival while a stamp is pending
		send_rec(16'h0001, 2'h0, 3'h0, 0, 1, 0);
		// Loss counter saturation
		send_rec(16'h0002, 2'h1, 3'h0, 1, 0, 65540);
		complete_run();
	end
endmodule // test_crf_framer
`default_nettype wire
